// ===== core/cie_core.sv
// Purpose: receive irq enable and transmit empty flag registers with irq gating
// Assumes: events are one-cycle pulses synchronous to i_clk_sys; rx_full and counters are levels
// Notes:
// Notes on behaviour
// - receive irq enable bits 7:6 and 1:0 held at reset value while init request and acknowledge both set
// - receiver and transmitter sensitivity fields survive entry into init mode
// - receive irq enable always readable, writable only outside init mode
// - bit 7 gates wake-up events into the wake-up irq request
// - bit 6 gates status change into the error irq request
// - bits 5:4 pick receiver changes: none, bus-off, error/bus-off, all
// - bits 3:2 pick transmitter changes: none, bus-off, error/bus-off, all
// - bus state fields track real state, updated only while no status change pending
// - bit 1 gates receive overrun into the error irq request
// - bit 0 gates receive-full into the receiver irq request
// - transmit empty flags held at reset state in init mode
// - with init request and acknowledge both clear and not listen-only, write one clears an empty flag, zero ignored; always readable
// - empty flag set when its buffer is sent successfully
// - empty flag set when an abort of its buffer succeeds
// - transmit irq pending while any empty flag set and enabled
// - clearing an empty flag clears that buffer's abort acknowledge
// - setting an empty flag clears that buffer's abort request
// - listen-only mode refuses flag clears and starts no transmission
// - host access to a scheduled buffer is blocked
// - three empty flags in bits 2:0, one means empty and unscheduled
// - receiver state 00 to 96, 01 to 127, 10 above, 11 bus-off
// - bus state change selected by the sensitivity fields sets status change flag, fields frozen until cleared
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ns
module cie_core #(
   parameter int NUM_TXBUF = 3
) (
   input  wire logic                i_clk_sys,
   input  wire logic                i_resetn,
   input  wire cie_pkg::cie_wb_req_t i_wb,
   output logic [31:0]              o_wb_dat,
   output logic                     o_wb_ack,
   input  wire cie_pkg::cie_evt_t   i_evt,
   input  wire logic [2:0]          i_tx_irq_en,
   input  wire logic                i_init_ack,
   output logic                     o_init_req,
   output logic                     o_listen_only,
   output logic [2:0]               o_tx_buffer_empty,
   output logic [2:0]               o_tx_start_ok,
   output logic [2:0]               o_tx_buf_blocked,
   output logic [2:0]               o_abort_req_clr,
   output logic [2:0]               o_abort_ack_clr,
   output logic                     o_wakeup_irq,
   output logic                     o_error_irq,
   output logic                     o_rx_irq,
   output logic                     o_tx_irq
);
   import cie_pkg::*;

   if (NUM_TXBUF != CIE_NUM_TXBUF) begin
      $error("cie_core: NUM_TXBUF must be 3");
   end

   logic [7:0]  rier_q;
   logic [2:0]  txe_q;
   logic        wup_flag_q;
   logic        csc_flag_q;
   logic        ovr_flag_q;
   logic        rxf_flag_q;
   logic [1:0]  rx_st_q;
   logic [1:0]  tx_st_q;
   logic [1:0]  rx_real_q;
   logic [1:0]  tx_real_q;
   logic        init_request_q;
   logic        listen_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   logic [2:0]  abrq_clr_q;
   logic [2:0]  abak_clr_q;
   logic        wup_irq_q;
   logic        err_irq_q;
   logic        rx_irq_q;
   logic        tx_irq_q;
   logic [2:0]  start_q;
   logic [2:0]  blocked_q;

   function automatic logic [1:0] cie_rx_state(input logic [8:0] rec, input logic [8:0] tec);
      logic [1:0] s;
      s = 2'b00;
      if (tec > CIE_CNT_BUSOFF) s = 2'b11;
      else if (rec > CIE_CNT_ERR) s = 2'b10;
      else if (rec > CIE_CNT_WARN) s = 2'b01;
      return s;
   endfunction

   function automatic logic [1:0] cie_tx_state(input logic [8:0] tec);
      logic [1:0] s;
      s = 2'b00;
      if (tec > CIE_CNT_BUSOFF) s = 2'b11;
      else if (tec > CIE_CNT_ERR) s = 2'b10;
      else if (tec > CIE_CNT_WARN) s = 2'b01;
      return s;
   endfunction

   // does a change from old to new count under the given sensitivity
   function automatic logic cie_sens_hit(input logic [1:0] sens, input logic [1:0] o,
                                         input logic [1:0] n);
      logic h;
      h = 1'b0;
      if (o != n) begin
         unique case (sens)
            2'b00: h = 1'b0;
            2'b01: h = (o == 2'b11) || (n == 2'b11);
            2'b10: h = o[1] || n[1];
            2'b11: h = 1'b1;
         endcase
      end
      return h;
   endfunction

   // bus decode
   wire        wb_req   = i_wb.cyc && i_wb.stb && !ack_q;
   wire        wb_wr    = wb_req && i_wb.we && i_wb.sel[0];
   wire        in_init  = init_request_q && i_init_ack;
   wire        hit_rier = (i_wb.adr == CIE_ADR_RIER);
   wire        hit_tflg = (i_wb.adr == CIE_ADR_TFLG);
   wire        hit_stat = (i_wb.adr == CIE_ADR_STAT);
   wire        hit_mode = (i_wb.adr == CIE_ADR_MODE);
   wire [7:0]  wbyte    = i_wb.dat[7:0];

   wire        wr_rier  = wb_wr && hit_rier && !init_request_q && !i_init_ack;
   wire        wr_tflg  = wb_wr && hit_tflg && !init_request_q && !i_init_ack && !listen_q;
   wire        wr_stat  = wb_wr && hit_stat;
   wire        wr_mode  = wb_wr && hit_mode;

   wire [2:0]  txe_set  = i_evt.tx_done | i_evt.abort_done;
   wire [2:0]  txe_clr  = wr_tflg ? wbyte[2:0] : 3'b000;
   // set wins over a clear in the same cycle
   wire [2:0]  txe_d    = (txe_q & ~txe_clr) | txe_set;
   wire [2:0]  txe_nx   = in_init ? CIE_RST_TXE : txe_d;
   wire        listen_d = wr_mode ? wbyte[CIE_BIT_LISTEN] : listen_q;

   wire [1:0]  rx_new   = cie_rx_state(i_evt.rx_err_cnt, i_evt.tx_err_cnt);
   wire [1:0]  tx_new   = cie_tx_state(i_evt.tx_err_cnt);
   wire        csc_evt  = cie_sens_hit(rier_q[CIE_POS_RXSENS+:2], rx_real_q, rx_new)
                       || cie_sens_hit(rier_q[CIE_POS_TXSENS+:2], tx_real_q, tx_new);
   wire        csc_clr  = wr_stat && wbyte[CIE_BIT_SCSC];
   wire        csc_d    = csc_evt || (csc_flag_q && !csc_clr);

   wire [7:0]  stat_rd  = {tx_st_q, rx_st_q, 1'b0, ovr_flag_q, csc_flag_q, wup_flag_q};
   wire [7:0]  mode_rd  = {i_init_ack, 5'h00, listen_q, init_request_q};
   wire [7:0]  rd_byte  = hit_rier ? rier_q :
                          hit_tflg ? {5'h00, txe_q} :
                          hit_stat ? stat_rd :
                          hit_mode ? mode_rd : 8'h00;

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ack_q  <= 1'b0;
         rdat_q <= CIE_RD_UNMAPPED;
      end else begin
         ack_q  <= wb_req;
         rdat_q <= wb_req ? {24'h000000, rd_byte} : CIE_RD_UNMAPPED;
      end
   end

   // receive irq enable register
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         rier_q <= CIE_RST_RIER;
      end else if (in_init) begin
         // sensitivity bits keep their value across init
         rier_q <= (CIE_RST_RIER & 8'hc3) | (rier_q & 8'h3c);
      end else if (wr_rier) begin
         rier_q <= wbyte;
      end
   end

   // transmit empty flags
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         txe_q      <= CIE_RST_TXE;
         abrq_clr_q <= 3'b000;
         abak_clr_q <= 3'b000;
      end else if (in_init) begin
         txe_q      <= CIE_RST_TXE;
         abrq_clr_q <= 3'b000;
         abak_clr_q <= 3'b000;
      end else begin
         txe_q      <= txe_d;
         abrq_clr_q <= ~txe_q & txe_d;
         abak_clr_q <= txe_clr & txe_q & ~txe_set;
      end
   end

   // receive-side flags and frozen bus states
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         wup_flag_q <= 1'b0;
         csc_flag_q <= 1'b0;
         ovr_flag_q <= 1'b0;
         rxf_flag_q <= 1'b0;
         rx_st_q    <= 2'b00;
         tx_st_q    <= 2'b00;
         rx_real_q  <= 2'b00;
         tx_real_q  <= 2'b00;
      end else begin
         wup_flag_q <= i_evt.wakeup || (wup_flag_q && !(wr_stat && wbyte[CIE_BIT_SWUP]));
         ovr_flag_q <= i_evt.overrun || (ovr_flag_q && !(wr_stat && wbyte[CIE_BIT_SOVR]));
         rxf_flag_q <= i_evt.rx_full;
         csc_flag_q <= csc_d;
         rx_real_q  <= rx_new;
         tx_real_q  <= tx_new;
         if (!csc_flag_q) begin
            rx_st_q <= rx_new;
            tx_st_q <= tx_new;
         end
      end
   end

   // mode controls
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         init_request_q <= 1'b0;
         listen_q <= 1'b0;
      end else if (wr_mode) begin
         init_request_q <= wbyte[CIE_BIT_INIT_REQ];
         listen_q <= wbyte[CIE_BIT_LISTEN];
      end
   end

   // built from next-state values so they never lag the flags
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         start_q   <= 3'b000;
         blocked_q <= 3'b000;
      end else begin
         start_q   <= listen_d ? 3'b000 : ~txe_nx;
         blocked_q <= ~txe_nx;
      end
   end

   // irq outputs, registered every cycle
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         wup_irq_q <= 1'b0;
         err_irq_q <= 1'b0;
         rx_irq_q  <= 1'b0;
         tx_irq_q  <= 1'b0;
      end else begin
         wup_irq_q <= wup_flag_q && rier_q[CIE_BIT_WAKE_EN];
         err_irq_q <= (csc_flag_q && rier_q[CIE_BIT_CSC_EN])
                   || (ovr_flag_q && rier_q[CIE_BIT_OVR_EN]);
         rx_irq_q  <= rxf_flag_q && rier_q[CIE_BIT_RXF_EN];
         tx_irq_q  <= |(txe_q & i_tx_irq_en);
      end
   end

   assign o_wb_dat          = rdat_q;
   assign o_wb_ack          = ack_q;
   assign o_init_req        = init_request_q;
   assign o_listen_only     = listen_q;
   assign o_tx_buffer_empty = txe_q;
   assign o_tx_start_ok     = start_q;
   assign o_tx_buf_blocked  = blocked_q;
   assign o_abort_req_clr   = abrq_clr_q;
   assign o_abort_ack_clr   = abak_clr_q;
   assign o_wakeup_irq      = wup_irq_q;
   assign o_error_irq       = err_irq_q;
   assign o_rx_irq          = rx_irq_q;
   assign o_tx_irq          = tx_irq_q;

   // assertions
   property p_rier_init;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      in_init |=> ((rier_q & 8'hc3) == (CIE_RST_RIER & 8'hc3));
   endproperty
   a_rier_init: assert property (p_rier_init) else $error("rier not held in init");

   property p_sens_keep;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      in_init |=> (rier_q[5:2] == $past(rier_q[5:2]));
   endproperty
   a_sens_keep: assert property (p_sens_keep) else $error("sensitivity lost in init");

   property p_rier_wr;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (wb_wr && hit_rier && !init_request_q && !i_init_ack) |=> (rier_q == $past(wbyte));
   endproperty
   a_rier_wr: assert property (p_rier_wr) else $error("rier write lost");

   property p_txe_init;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      in_init |=> (txe_q == CIE_RST_TXE);
   endproperty
   a_txe_init: assert property (p_txe_init) else $error("txe not reset in init");

   property p_txe_set;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (!in_init && |txe_set) |=> ((txe_q & $past(txe_set)) == $past(txe_set));
   endproperty
   a_txe_set: assert property (p_txe_set) else $error("txe not set on done");

   property p_listen;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (listen_q && !in_init) |=> ((txe_q & $past(txe_q)) == $past(txe_q));
   endproperty
   a_listen: assert property (p_listen) else $error("txe cleared in listen");

   sequence s_set_edge;
      !in_init && |(~txe_q & txe_set);
   endsequence
   property p_abrq;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      s_set_edge |=> (abrq_clr_q == (txe_q & ~$past(txe_q)));
   endproperty
   a_abrq: assert property (p_abrq) else $error("abort request not cleared");

   property p_txirq;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      |(txe_q & i_tx_irq_en) |=> o_tx_irq;
   endproperty
   a_txirq: assert property (p_txirq) else $error("tx irq missing");

   property p_freeze;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      csc_flag_q |=> (rx_st_q == $past(rx_st_q) && tx_st_q == $past(tx_st_q));
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while pending");

   property p_wupirq;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (wup_flag_q && !rier_q[CIE_BIT_WAKE_EN]) |=> !o_wakeup_irq;
   endproperty
   a_wupirq: assert property (p_wupirq) else $error("wake irq while masked");

   property p_csc_irq;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (csc_flag_q && rier_q[CIE_BIT_CSC_EN]) |=> o_error_irq;
   endproperty
   a_csc_irq: assert property (p_csc_irq) else $error("status change irq missing");

   property p_ovr_irq;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (ovr_flag_q && rier_q[CIE_BIT_OVR_EN]) |=> o_error_irq;
   endproperty
   a_ovr_irq: assert property (p_ovr_irq) else $error("overrun irq missing");

   property p_rx_irq;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (rxf_flag_q && rier_q[CIE_BIT_RXF_EN]) |=> o_rx_irq;
   endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("receive irq missing");

   property p_w1c;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      wr_tflg |=> ((txe_q & $past(wbyte[2:0] & ~txe_set)) == 3'b000);
   endproperty
   a_w1c: assert property (p_w1c) else $error("empty flag not cleared");

   property p_abak;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (wr_tflg && |(wbyte[2:0] & txe_q)) |=> (abak_clr_q == ($past(txe_q) & ~txe_q));
   endproperty
   a_abak: assert property (p_abak) else $error("abort ack clear wrong");

   property p_start;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      listen_q |-> (o_tx_start_ok == 3'b000);
   endproperty
   a_start: assert property (p_start) else $error("start allowed in listen");

   property p_blocked;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      o_tx_buf_blocked == ~txe_q;
   endproperty
   a_blocked: assert property (p_blocked) else $error("block does not match flags");

   property p_rx_boff;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (!csc_flag_q && i_evt.tx_err_cnt > CIE_CNT_BUSOFF) |=> (rx_st_q == 2'b11);
   endproperty
   a_rx_boff: assert property (p_rx_boff) else $error("receiver not bus-off");

   property p_csc_set;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (rier_q[CIE_POS_RXSENS+:2] == 2'b11 && rx_new != rx_real_q) |=> csc_flag_q;
   endproperty
   a_csc_set: assert property (p_csc_set) else $error("status change not flagged");
endmodule

// ===== core/cie_pkg.sv
// Purpose: shared constants and types for the receive irq enable / transmit empty flags block
// Assumes: classic wishbone with 32-bit data, byte registers in the low lane
// Notes:   printed offsets are indices; byte address is four times the index
package cie_pkg;
   localparam int          CIE_ADDR_W       = 6;
   localparam int          CIE_NUM_TXBUF    = 3;
   // register indices and byte addresses
   localparam logic [3:0]  CIE_IDX_RIER     = 4'h5;
   localparam logic [3:0]  CIE_IDX_TFLG     = 4'h6;
   localparam logic [3:0]  CIE_IDX_STAT     = 4'h8;
   localparam logic [3:0]  CIE_IDX_MODE     = 4'h9;
   localparam logic [CIE_ADDR_W-1:0] CIE_ADR_RIER = {CIE_IDX_RIER, 2'b00};
   localparam logic [CIE_ADDR_W-1:0] CIE_ADR_TFLG = {CIE_IDX_TFLG, 2'b00};
   localparam logic [CIE_ADDR_W-1:0] CIE_ADR_STAT = {CIE_IDX_STAT, 2'b00};
   localparam logic [CIE_ADDR_W-1:0] CIE_ADR_MODE = {CIE_IDX_MODE, 2'b00};
   // receive irq enable fields
   localparam int          CIE_BIT_WAKE_EN  = 7;
   localparam int          CIE_BIT_CSC_EN   = 6;
   localparam int          CIE_POS_RXSENS   = 4;
   localparam int          CIE_POS_TXSENS   = 2;
   localparam int          CIE_BIT_OVR_EN   = 1;
   localparam int          CIE_BIT_RXF_EN   = 0;
   // status register fields (index 8): flags low, bus states high
   localparam int          CIE_BIT_SWUP     = 0;
   localparam int          CIE_BIT_SCSC     = 1;
   localparam int          CIE_BIT_SOVR     = 2;
   localparam int          CIE_POS_RXST     = 4;
   localparam int          CIE_POS_TXST     = 6;
   // mode register fields (index 9)
   localparam int          CIE_BIT_INIT_REQ = 0;
   localparam int          CIE_BIT_LISTEN   = 1;
   localparam int          CIE_BIT_INIT_ACK = 7;
   // reset values
   localparam logic [7:0]  CIE_RST_RIER     = 8'h00;
   localparam logic [2:0]  CIE_RST_TXE      = 3'h7;
   localparam logic [31:0] CIE_RD_UNMAPPED  = 32'h0000_0000;
   // error counter thresholds
   localparam logic [8:0]  CIE_CNT_WARN     = 9'h060;
   localparam logic [8:0]  CIE_CNT_ERR      = 9'h07f;
   localparam logic [8:0]  CIE_CNT_BUSOFF   = 9'h0ff;

   typedef enum logic [1:0] {
      CIE_ST_OK,
      CIE_ST_WRN,
      CIE_ST_ERR,
      CIE_ST_BOFF
   } cie_state_t;

   typedef struct packed {
      logic                  cyc;
      logic                  stb;
      logic                  we;
      logic [3:0]            sel;
      logic [CIE_ADDR_W-1:0] adr;
      logic [31:0]           dat;
   } cie_wb_req_t;

   typedef struct packed {
      logic        wakeup;
      logic        overrun;
      logic        rx_full;
      logic [2:0]  tx_done;
      logic [2:0]  abort_done;
      logic [8:0]  rx_err_cnt;
      logic [8:0]  tx_err_cnt;
   } cie_evt_t;
endpackage

// ===== bench/cie_can_model.sv
// Purpose: behavioural protocol-engine side: init handshake and transmit completion
// Assumes: a buffer is sent TX_DLY+1 cycles after it becomes startable
// Notes:   raise ACK_DLY or TX_DLY to model a slow engine
`timescale 1ns/1ns
module cie_can_model #(
   parameter int ACK_DLY = 4,
   parameter int TX_DLY  = 16
) (
   input  wire logic       i_clk_sys,
   input  wire logic       i_resetn,
   input  wire logic       i_init_req,
   input  wire logic [2:0] i_tx_start_ok,
   output logic            o_init_ack,
   output logic [2:0]      o_tx_done
);
   int ack_cnt;
   int tx_cnt [3];

   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ack_cnt    <= 0;
         o_init_ack <= 1'b0;
         o_tx_done  <= 3'h0;
         for (int b = 0; b < 3; b++) begin
            tx_cnt[b] <= 0;
         end
      end else begin
         ack_cnt    <= i_init_req ? ((ack_cnt < ACK_DLY) ? ack_cnt + 1 : ack_cnt) : 0;
         o_init_ack <= i_init_req && (ack_cnt == ACK_DLY);
         for (int b = 0; b < 3; b++) begin
            // nothing sent while listening or in init
            o_tx_done[b] <= i_tx_start_ok[b] && !o_init_ack && (tx_cnt[b] == TX_DLY);
            if (!i_tx_start_ok[b] || o_init_ack || tx_cnt[b] == TX_DLY) begin
               tx_cnt[b] <= 0;
            end else begin
               tx_cnt[b] <= tx_cnt[b] + 1;
            end
         end
      end
   end
endmodule

// ===== bench/tb_can_irq_enable_tx_empty_flags.sv
// Purpose: register-level tests of irq enables, status change and empty flags
// Assumes: wishbone acks one cycle after the taking edge
// Notes:   irq outputs are levels, checked a few cycles after their cause
`timescale 1ns/1ns
module tb_can_irq_enable_tx_empty_flags;
   import cie_pkg::*;
   logic             i_clk_sys = 1'b0;
   logic             i_resetn  = 1'b0;
   cie_wb_req_t      wb        = '0;
   cie_evt_t         ev        = '0;
   cie_evt_t         evt;
   logic [2:0]       tx_en     = 3'h7;
   logic [31:0]      rd_dat;
   logic             ack, init_req, init_ack, listen, wk_irq, er_irq, rx_irq, tx_irq;
   logic [2:0]       empty, start_ok, blocked, req_clr, ack_clr, done;
   logic [2:0]       req_seen, ack_seen;
   logic             clr_seen  = 1'b0;
   int               n_errors  = 0;
   int               check_count = 0;

   always #2 i_clk_sys = ~i_clk_sys;
   always_comb begin
      evt         = ev;
      evt.tx_done = done;
   end
   always @(posedge i_clk_sys) begin
      req_seen <= clr_seen ? 3'h0 : (req_seen | req_clr);
      ack_seen <= clr_seen ? 3'h0 : (ack_seen | ack_clr);
   end

   cie_core #(.NUM_TXBUF(3)) dut (
      .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_wb(wb), .o_wb_dat(rd_dat),
      .o_wb_ack(ack), .i_evt(evt), .i_tx_irq_en(tx_en), .i_init_ack(init_ack),
      .o_init_req(init_req), .o_listen_only(listen), .o_tx_buffer_empty(empty),
      .o_tx_start_ok(start_ok), .o_tx_buf_blocked(blocked), .o_abort_req_clr(req_clr),
      .o_abort_ack_clr(ack_clr), .o_wakeup_irq(wk_irq), .o_error_irq(er_irq),
      .o_rx_irq(rx_irq), .o_tx_irq(tx_irq));

   cie_can_model #(.ACK_DLY(4), .TX_DLY(16)) can (
      .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_init_req(init_req),
      .i_tx_start_ok(start_ok), .o_init_ack(init_ack), .o_tx_done(done));

   task automatic close_out();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic bus(input logic we, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      wb.cyc <= 1'b1; wb.stb <= 1'b1; wb.we <= we; wb.sel <= 4'hf;
      wb.adr <= a; wb.dat <= {24'h0, d};
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rd_dat[7:0];
      if (n >= 50) chk("ack", 8'h1, 8'h0);
      wb.cyc <= 1'b0; wb.stb <= 1'b0; wb.we <= 1'b0;
      @(posedge i_clk_sys);
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdc(input string nm, input logic [5:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hff);
      logic [7:0] q;
      bus(1'b0, a, 8'h0, q);
      chk(nm, e, q & m);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask

   initial begin
      repeat (40000) @(posedge i_clk_sys);
      n_errors++;
      close_out();
   end

   initial begin
      wt(20);
      i_resetn <= 1'b1;
      wt(2);
      rdc("rier rst", CIE_ADR_RIER, CIE_RST_RIER);
      rdc("tflg rst", CIE_ADR_TFLG, 8'h07);
      rdc("unmapped", 6'h3c, 8'h00);
      chk("tx irq", 8'h1, {7'h0, tx_irq});
      // wake-up gating, flag left standing while masked
      ev.wakeup <= 1'b1; wt(1); ev.wakeup <= 1'b0; wt(4);
      chk("wk irq off", 8'h0, {7'h0, wk_irq});
      wr(CIE_ADR_RIER, 8'h80); wt(4);
      chk("wk irq on", 8'h1, {7'h0, wk_irq});
      wr(CIE_ADR_STAT, 8'h01); wt(4);
      chk("wk irq clr", 8'h0, {7'h0, wk_irq});
      wr(CIE_ADR_RIER, 8'h02);
      ev.overrun <= 1'b1; wt(1); ev.overrun <= 1'b0; wt(4);
      chk("ovr irq", 8'h1, {7'h0, er_irq});
      wr(CIE_ADR_STAT, 8'h04); wr(CIE_ADR_RIER, 8'h01);
      ev.rx_full <= 1'b1; wt(4);
      chk("rx irq", 8'h1, {7'h0, rx_irq});
      ev.rx_full <= 1'b0; wr(CIE_ADR_RIER, 8'h00);
      // status change sensitivity
      ev.rx_err_cnt <= 9'd100; wt(4);
      rdc("sens none", CIE_ADR_STAT, 8'h10);
      wr(CIE_ADR_RIER, 8'h70);
      ev.rx_err_cnt <= 9'd130; wt(4);
      chk("csc irq", 8'h1, {7'h0, er_irq});
      rdc("rx err", CIE_ADR_STAT, 8'h22);
      ev.rx_err_cnt <= 9'd0; wt(4);
      rdc("frozen", CIE_ADR_STAT, 8'h22);
      wr(CIE_ADR_STAT, 8'h02); wt(4);
      rdc("thawed", CIE_ADR_STAT, 8'h00, 8'h30);
      wr(CIE_ADR_RIER, 8'h44);
      ev.tx_err_cnt <= 9'd130; wt(4);
      chk("tx sens err", 8'h0, {7'h0, er_irq});
      rdc("tx state", CIE_ADR_STAT, 8'h80, 8'hc2);
      ev.tx_err_cnt <= 9'd256; wt(4);
      chk("tx sens boff", 8'h1, {7'h0, er_irq});
      wr(CIE_ADR_RIER, 8'h00);
      ev.tx_err_cnt <= 9'd0; wt(4);
      wr(CIE_ADR_STAT, 8'h02); wt(4);
      chk("csc gone", 8'h0, {7'h0, er_irq});
      // empty flags: ignore zero, schedule, send, abort
      wr(CIE_ADR_TFLG, 8'h00);
      rdc("w0 ignored", CIE_ADR_TFLG, 8'h07);
      clr_seen <= 1'b1; wt(1); clr_seen <= 1'b0;
      wr(CIE_ADR_TFLG, 8'h01);
      rdc("sched", CIE_ADR_TFLG, 8'h06);
      chk("blocked", 8'h1, {5'h0, blocked});
      chk("empty", 8'h6, {5'h0, empty});
      chk("ack clr", 8'h1, {5'h0, ack_seen});
      wt(30);
      rdc("sent", CIE_ADR_TFLG, 8'h07);
      chk("req clr", 8'h1, {5'h0, req_seen});
      tx_en <= 3'h2;
      wr(CIE_ADR_TFLG, 8'h02); wt(2);
      chk("tx irq mask", 8'h0, {7'h0, tx_irq});
      ev.abort_done <= 3'h2; wt(1); ev.abort_done <= 3'h0; wt(4);
      rdc("aborted", CIE_ADR_TFLG, 8'h07);
      chk("tx irq set", 8'h1, {7'h0, tx_irq});
      tx_en <= 3'h7;
      // listen mode refuses scheduling and holds back a scheduled buffer
      wr(CIE_ADR_TFLG, 8'h01);
      wr(CIE_ADR_MODE, 8'h02);
      wr(CIE_ADR_TFLG, 8'h02);
      rdc("listen", CIE_ADR_TFLG, 8'h06);
      chk("listen out", 8'h1, {7'h0, listen});
      chk("no start", 8'h0, {5'h0, start_ok});
      wt(30);
      rdc("held", CIE_ADR_TFLG, 8'h06);
      wr(CIE_ADR_MODE, 8'h00); wt(30);
      rdc("resumed", CIE_ADR_TFLG, 8'h07);
      // init mode holds both registers, sensitivities kept
      wr(CIE_ADR_RIER, 8'h7d);
      wr(CIE_ADR_TFLG, 8'h04);
      wr(CIE_ADR_MODE, 8'h01); wt(10);
      rdc("rier init", CIE_ADR_RIER, 8'h3c);
      rdc("tflg init", CIE_ADR_TFLG, 8'h07);
      rdc("mode init", CIE_ADR_MODE, 8'h81);
      chk("init req", 8'h1, {7'h0, init_req});
      wr(CIE_ADR_RIER, 8'hff);
      rdc("rier locked", CIE_ADR_RIER, 8'h3c);
      wr(CIE_ADR_MODE, 8'h00); wt(10);
      wr(CIE_ADR_RIER, 8'h81);
      rdc("rier open", CIE_ADR_RIER, 8'h81);
      close_out();
   end
endmodule
